// ==== shared/dcp_pkg.sv ====
package dcp_pkg;
    // register byte offsets on the plain register port
    localparam logic [7:0] OFS_CRC_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CRC_CONFIG  = 8'h04;
    localparam logic [7:0] OFS_CRC_DATA    = 8'h08;
    localparam logic [7:0] OFS_STATUS      = 8'h0c;
    localparam logic [7:0] OFS_PATTERN0    = 8'h10;
    localparam logic [7:0] OFS_PATTERN_STEP = 8'h04;

    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int NUM_CH   = 4;
    localparam int CH_W     = 2;
    localparam int PAT_W    = 8;
    localparam int FIFO_DEPTH = 4;

    // crc_control_reg fields
    localparam int CTL_APPEND_BIT = 6;
    localparam int CTL_TYPE_BIT   = 5;
    localparam int CTL_CH_LSB     = 0;
    localparam int CTL_CH_W       = 3;

    // own config register fields
    localparam int CFG_WBO_BIT    = 0;
    localparam int CFG_PTERM_LSB  = 4;

    // status register fields
    localparam int STS_APPEND_BIT = 0;
    localparam int STS_UNALIGN_BIT = 1;

    // crc calculator constants and control channel reset value
    localparam logic [31:0] CRC_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC_SEED_RESET = 32'hffffffff;
    localparam logic [CTL_CH_W-1:0] CH_RESET = 3'h0;

    typedef enum logic {DCP_TYPE_LFSR, DCP_TYPE_IPSUM} dcp_type_e;
    typedef enum {DCP_IDLE, DCP_APPEND} dcp_state_e;
endpackage

// ==== core/dcp_crc_calc.sv ====
`timescale 1ns/10ps
module dcp_crc_calc
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        seedWr,
    input  wire logic [31:0] seedData,
    input  wire logic        update,
    input  wire logic        ipMode,
    input  wire logic [31:0] dataIn,
    output logic      [31:0] result
);
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [31:0] lfsrNext;
    logic [16:0] sumLo;
    logic [16:0] sumHi;
    logic [15:0] ipNext;

    // one word of msb-first lfsr crc, folded bit by bit
    always_comb
    begin
        lfsrNext = acc_r;
        for (int i = 31; i >= 0; i--)
        begin
            if (lfsrNext[31] ^ dataIn[i])
                lfsrNext = (lfsrNext << 1) ^ dcp_pkg::CRC_POLY;
            else
                lfsrNext = lfsrNext << 1;
        end
    end

    // ones-complement sum of both halfwords, end-around carry twice
    assign sumLo  = {1'b0, acc_r[15:0]} + {1'b0, dataIn[15:0]};
    assign sumHi  = {1'b0, sumLo[15:0]} + {16'h0000, sumLo[16]}
                  + {1'b0, dataIn[31:16]};
    assign ipNext = sumHi[15:0] + {15'h0000, sumHi[16]};

    assign acc_nxt = seedWr ? seedData
                   : !update ? acc_r
                   : ipMode ? {16'h0000, ipNext} : lfsrNext;

    // checksum reads complemented, lfsr reads raw
    assign result = ipMode ? {16'h0000, ~acc_r[15:0]} : acc_r;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            acc_r <= dcp_pkg::CRC_SEED_RESET;
        else
            acc_r <= acc_nxt;
    end
endmodule

// ==== core/dcp_fifo.sv ====
`timescale 1ns/10ps
module dcp_fifo
#(
    parameter int WIDTH = 33,
    parameter int DEPTH = 4
)
(
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int LW = $clog2(DEPTH+1);
    // shift style: head always sits in mem[0] so the output is a flop
    logic [WIDTH-1:0] mem [DEPTH];
    logic [LW-1:0]    cnt_r;
    logic             push;
    logic             pop;
    logic [LW-1:0]    wrIdx;

    assign inReady  = (cnt_r != LW'(DEPTH));
    assign outValid = (cnt_r != '0);
    assign outData  = mem[0];
    assign level    = cnt_r;
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign wrIdx    = pop ? cnt_r - LW'(1) : cnt_r;

    // occupancy counter
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + LW'(push) - LW'(pop);
    end

    // storage, shifts toward the head on every pop
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : gEntry
            always_ff @(posedge sys_clk)
            begin
                if (push && wrIdx == LW'(g))
                    mem[g] <= inData;
                else if (pop && g < DEPTH-1)
                    mem[g] <= mem[(g+1) % DEPTH];
            end
        end
    endgenerate
endmodule

// ==== core/dcp_crc_pattern.sv ====
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
// Functional notes
// [RULE1] append mode: selected channel data feeds crc only, nothing to dest
// [RULE2] append mode: at block end crc result goes to dest start address
// [RULE3] no append: data goes through crc and to dest, byte order applied
// [RULE4] type bit: 1 selects ip header checksum, 0 selects lfsr crc
// [RULE5] three-bit channel select, codes 0-3 pick channel, 4-7 reserved
// [RULE6] control bits 4 and 3 read as zero
// [RULE7] byte order set: unaligned data refused, append bit cannot be set
// [RULE8] pattern terminate: match low byte against pattern, end transfer
// [RULE9] other modes ignore the pattern byte entirely
// [RULE10] pattern register upper 24 bits read zero, low byte rw, reset zero
// [RULE11] only the selected channel updates the crc accumulator
module dcp_crc_pattern
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic        inValid,
    output logic             inReady,
    input  wire logic [31:0] inData,
    input  wire logic [1:0]  inChannel,
    input  wire logic        inLast,
    input  wire logic        inUnaligned,
    output logic             outValid,
    input  wire logic        outReady,
    output logic      [31:0] outData,
    output logic             outCrcWrite,
    output logic      [3:0]  patternMatch
);
    localparam int FW = dcp_pkg::DATA_W + 1;
    localparam int LW = $clog2(dcp_pkg::FIFO_DEPTH + 1);
    localparam logic [LW-1:0] READY_LEVEL = LW'(dcp_pkg::FIFO_DEPTH - 2);

    // control and configuration state
    logic                          appendMode_r;
    logic                          crcType_r;
    logic [dcp_pkg::CTL_CH_W-1:0]  crcChannel_r;
    logic                          wbo_r;
    logic [dcp_pkg::NUM_CH-1:0]    patTermEn_r;
    logic [dcp_pkg::PAT_W-1:0]     pattern_r [dcp_pkg::NUM_CH];
    logic                          unalignErr_r;
    logic                          inReady_r;
    logic                          inReady_nxt;
    logic [31:0]                   regRdata_r;
    logic [31:0]                   regRdata_nxt;
    logic [dcp_pkg::NUM_CH-1:0]    patternMatch_r;
    dcp_pkg::dcp_state_e           state_r;
    dcp_pkg::dcp_state_e           state_nxt;

    // register decode
    wire wrCtl   = regWr && regAddr == dcp_pkg::OFS_CRC_CONTROL;
    wire wrCfg   = regWr && regAddr == dcp_pkg::OFS_CRC_CONFIG;
    wire wrData  = regWr && regAddr == dcp_pkg::OFS_CRC_DATA;
    wire wrSts   = regWr && regAddr == dcp_pkg::OFS_STATUS;

    // stream decode
    wire        accept    = inValid && inReady_r;
    wire        chValid   = !crcChannel_r[dcp_pkg::CTL_CH_W-1]; // RULE5
    wire        selHit    = chValid
                          && inChannel == crcChannel_r[dcp_pkg::CH_W-1:0];
    wire        drop      = accept && wbo_r && inUnaligned; // RULE7
    wire        crcUpdate = accept && selHit && !drop; // RULE11
    wire        absorb    = selHit && appendMode_r; // RULE1
    wire        forward   = accept && !drop && !absorb; // RULE3
    wire        goAppend  = accept && !drop && absorb && inLast; // RULE2
    wire [31:0] swapped   = {inData[7:0], inData[15:8],
                             inData[23:16], inData[31:24]};
    wire [31:0] destData  = wbo_r ? swapped : inData; // RULE3
    wire [31:0] crcResult;
    wire        fifoInReady;
    wire [LW-1:0] fifoLevel;
    wire        appendPush = state_r == dcp_pkg::DCP_APPEND && fifoInReady;
    wire        push      = (forward && fifoInReady) || appendPush;
    wire [FW-1:0] pushWord = appendPush ? {1'b1, crcResult} // RULE2
                                        : {1'b0, destData};
    wire [FW-1:0] headWord;

    // appending refuses further input until the result is queued
    assign state_nxt = goAppend ? dcp_pkg::DCP_APPEND
                     : appendPush ? dcp_pkg::DCP_IDLE : state_r;
    // ready looks one push ahead so an accepted word always finds room
    assign inReady_nxt = fifoLevel <= READY_LEVEL
                       && state_nxt == dcp_pkg::DCP_IDLE;

    // crc accumulator, software seeds it through the data register
    dcp_crc_calc u_crc
    (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .seedWr   (wrData),
        .seedData (regWdata),
        .update   (crcUpdate),
        .ipMode   (crcType_r), // RULE4
        .dataIn   (inData),
        .result   (crcResult)
    );

    // destination queue, outputs come from its head flops
    dcp_fifo
    #(
        .WIDTH (FW),
        .DEPTH (dcp_pkg::FIFO_DEPTH)
    )
    u_fifo
    (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .inValid  (push),
        .inReady  (fifoInReady),
        .inData   (pushWord),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (headWord),
        .level    (fifoLevel)
    );

    assign outData     = headWord[dcp_pkg::DATA_W-1:0];
    assign outCrcWrite = headWord[dcp_pkg::DATA_W];

    // control register: append refused while byte order is set
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            appendMode_r <= 1'b0;
            crcType_r    <= 1'b0;
            crcChannel_r <= dcp_pkg::CH_RESET;
        end
        else if (wrCtl)
        begin
            appendMode_r <= regWdata[dcp_pkg::CTL_APPEND_BIT]
                            && !wbo_r; // RULE7
            crcType_r    <= regWdata[dcp_pkg::CTL_TYPE_BIT]; // RULE4
            crcChannel_r <= regWdata[dcp_pkg::CTL_CH_LSB +:
                                     dcp_pkg::CTL_CH_W]; // RULE5
        end
        else if (wrCfg && regWdata[dcp_pkg::CFG_WBO_BIT])
            appendMode_r <= 1'b0; // RULE7
    end

    // config register: byte order and per-channel terminate enables
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            wbo_r       <= 1'b0;
            patTermEn_r <= '0;
        end
        else if (wrCfg)
        begin
            wbo_r       <= regWdata[dcp_pkg::CFG_WBO_BIT];
            patTermEn_r <= regWdata[dcp_pkg::CFG_PTERM_LSB +:
                                    dcp_pkg::NUM_CH];
        end
    end

    // unaligned refusal flag, write one to clear, a new event wins
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            unalignErr_r <= 1'b0;
        else if (drop)
            unalignErr_r <= 1'b1; // RULE7
        else if (wrSts && regWdata[dcp_pkg::STS_UNALIGN_BIT])
            unalignErr_r <= 1'b0;
    end

    // per-channel pattern byte and terminate-on-match detector
    genvar c;
    generate
        for (c = 0; c < dcp_pkg::NUM_CH; c++)
        begin : gChan
            wire wrPat = regWr && regAddr == dcp_pkg::OFS_PATTERN0
                         + 8'(c) * dcp_pkg::OFS_PATTERN_STEP;
            wire hit   = accept && !drop && inChannel == 2'(c)
                         && patTermEn_r[c] // RULE9
                         && inData[dcp_pkg::PAT_W-1:0] == pattern_r[c];
            always_ff @(posedge sys_clk)
            begin
                if (srst)
                    pattern_r[c] <= '0; // RULE10
                else if (wrPat)
                    pattern_r[c] <= regWdata[dcp_pkg::PAT_W-1:0];
            end
            always_ff @(posedge sys_clk)
            begin
                if (srst)
                    patternMatch_r[c] <= 1'b0;
                else
                    patternMatch_r[c] <= hit; // RULE8
            end
        end
    endgenerate

    // read mux, answer is valid only in the cycle after the strobe
    always_comb
    begin
        regRdata_nxt = '0;
        if (regRd)
        begin
            case (regAddr)
                dcp_pkg::OFS_CRC_CONTROL:
                begin
                    regRdata_nxt[dcp_pkg::CTL_APPEND_BIT] = appendMode_r;
                    regRdata_nxt[dcp_pkg::CTL_TYPE_BIT]   = crcType_r;
                    regRdata_nxt[dcp_pkg::CTL_CH_LSB +: dcp_pkg::CTL_CH_W]
                        = crcChannel_r; // RULE6
                end
                dcp_pkg::OFS_CRC_CONFIG:
                begin
                    regRdata_nxt[dcp_pkg::CFG_WBO_BIT] = wbo_r;
                    regRdata_nxt[dcp_pkg::CFG_PTERM_LSB +: dcp_pkg::NUM_CH]
                        = patTermEn_r;
                end
                dcp_pkg::OFS_CRC_DATA:
                    regRdata_nxt = crcResult;
                dcp_pkg::OFS_STATUS:
                begin
                    regRdata_nxt[dcp_pkg::STS_APPEND_BIT]
                        = state_r == dcp_pkg::DCP_APPEND;
                    regRdata_nxt[dcp_pkg::STS_UNALIGN_BIT] = unalignErr_r;
                end
                default:
                begin
                    for (int k = 0; k < dcp_pkg::NUM_CH; k++)
                    begin
                        if (regAddr == dcp_pkg::OFS_PATTERN0
                            + 8'(k) * dcp_pkg::OFS_PATTERN_STEP)
                            regRdata_nxt[dcp_pkg::PAT_W-1:0]
                                = pattern_r[k]; // RULE10
                    end
                end
            endcase
        end
    end

    // sequencing, ready and read data flops
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_r    <= dcp_pkg::DCP_IDLE;
            inReady_r  <= 1'b0;
            regRdata_r <= '0;
        end
        else
        begin
            state_r    <= state_nxt;
            inReady_r  <= inReady_nxt;
            regRdata_r <= regRdata_nxt;
        end
    end

    assign inReady      = inReady_r;
    assign regRdata     = regRdata_r;
    assign patternMatch = patternMatch_r;
endmodule

// ==== verification/dcp_crc_pattern_properties.sv ====
`timescale 1ns/10ps
module dcp_crc_pattern_properties
(
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        inValid,
    input wire logic        inReady,
    input wire logic [1:0]  inChannel,
    input wire logic        inLast,
    input wire logic        outValid,
    input wire logic        outReady,
    input wire logic [31:0] outData,
    input wire logic        outCrcWrite,
    input wire logic [3:0]  patternMatch
);
    logic       wboR;
    logic       appR;
    logic [2:0] chR;
    logic       rdCtl;
    logic       selIn;
    // decoded read of control, and a word of the appending channel
    assign rdCtl = regRd && regAddr == dcp_pkg::OFS_CRC_CONTROL;
    assign selIn = inValid && inReady && appR && {1'b0, inChannel} == chR;
    // mirror of the mode bits; stream checks cannot see registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            wboR <= 1'b0;
            appR <= 1'b0;
            chR  <= 3'h0;
        end
        else if (regWr && regAddr == dcp_pkg::OFS_CRC_CONTROL)
        begin
            appR <= regWdata[6] && !wboR;
            chR  <= regWdata[2:0];
        end
        else if (regWr && regAddr == dcp_pkg::OFS_CRC_CONFIG)
        begin
            wboR <= regWdata[0];
            appR <= appR && !regWdata[0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_rd_idle;
        !regRd |=> regRdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
    property p_ctl_zero;
        rdCtl |=> regRdata[31:7] == 25'h0 && regRdata[4:3] == 2'h0;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero)
        else $error("control unused bits not zero");
    property p_pat_zero;
        regRd && regAddr[7:4] == 4'h1 |=> regRdata[31:8] == 24'h0;
    endproperty
    a_pat_zero: assert property (p_pat_zero)
        else $error("pattern upper bits not zero");
    property p_wbo_app;
        rdCtl && wboR |=> !regRdata[6];
    endproperty
    a_wbo_app: assert property (p_wbo_app)
        else $error("append set while byte order swapped");
    property p_match;
        |patternMatch |-> $past(inValid && inReady)
            && patternMatch == 4'h1 << $past(inChannel);
    endproperty
    a_match: assert property (p_match)
        else $error("match pulse without a taken word");
    property p_out_hold;
        outValid && !outReady |=> outValid && $stable(outData)
            && $stable(outCrcWrite);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("output word changed while stalled");
    property p_app_stall;
        selIn && inLast |=> !inReady;
    endproperty
    a_app_stall: assert property (p_app_stall)
        else $error("input not held off at block end");
    property p_app_crc;
        selIn && inLast |-> ##[2:60] outValid && outCrcWrite;
    endproperty
    a_app_crc: assert property (p_app_crc)
        else $error("crc word not offered after block end");
    c_append: cover property (selIn && inLast);
    c_match: cover property (|patternMatch);
    c_full: cover property (inValid && !inReady);
endmodule

// ==== verification/dcp_dest_model.sv ====
`timescale 1ns/10ps
module dcp_dest_model
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic [1:0] mode,
    output logic            outReady
);
    // 0 prompt, 1 stalls at random, 2 stalled; memory may stall at will
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            outReady <= 1'b0;
        else
            outReady <= mode == 2'd0 || (mode == 2'd1 && $urandom % 3 != 0);
    end
endmodule

// ==== verification/dcp_crc_pattern_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        checkCount++; \
        if ((g) !== (e)) \
        begin \
            badCount++; \
            $display("[ERR] %s exp %h got %h", nm, e, g); \
        end \
    end
module dcp_crc_pattern_tb_top;
    localparam logic [7:0] CTL = dcp_pkg::OFS_CRC_CONTROL;
    localparam logic [7:0] CFG = dcp_pkg::OFS_CRC_CONFIG;
    localparam logic [7:0] CRC = dcp_pkg::OFS_CRC_DATA;
    localparam logic [7:0] STS = dcp_pkg::OFS_STATUS;
    localparam logic [7:0] PAT = dcp_pkg::OFS_PATTERN0;
    logic        sys_clk, inReady, outValid, outReady, outCrcWrite;
    logic        srst = 1'b1, regWr = 1'b0, regRd = 1'b0, inValid = 1'b0;
    logic        inLast = 1'b0, inUnaligned = 1'b0;
    logic        rdPend = 1'b0, pmPend = 1'b0;
    logic [1:0]  inChannel = 2'h0, sinkMode = 2'h0;
    logic [3:0]  patternMatch, ePm;
    logic [7:0]  regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0, inData = 32'h0, regRdata, outData;
    logic [31:0] eRd, acc, w[4];
    logic [32:0] eOut;
    logic [31:0] rdQ[$];
    logic [32:0] outQ[$];
    logic [3:0]  pmQ[$];
    int          badCount = 0, checkCount = 0, cycles = 0;
    dcp_crc_pattern DUT
    (
        .sys_clk, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .inValid, .inReady, .inData, .inChannel, .inLast, .inUnaligned,
        .outValid, .outReady, .outData, .outCrcWrite, .patternMatch
    );
    dcp_dest_model sink (.sys_clk, .srst, .mode(sinkMode), .outReady);
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr(logic [31:0] c, logic [31:0] d);
        for (int i = 31; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ (c[31] ^ d[i] ? dcp_pkg::CRC_POLY : 32'h0);
        return c;
    endfunction
    function automatic logic [15:0] ocs(logic [31:0] d);
        logic [16:0] s;
        s = d[31:16] + d[15:0];
        return s[15:0] + 16'(s[16]);
    endfunction
    // strobes are set together, so none is driven twice in one step
    task automatic wr(logic [7:0] a, logic [31:0] d);
        {regWr, regRd, inValid} <= 3'b100;
        {regAddr, regWdata} <= {a, d};
        @(posedge sys_clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        {regWr, regRd, inValid} <= 3'b010;
        regAddr <= a;
        rdQ.push_back(e);
        @(posedge sys_clk);
    endtask
    task automatic idle(int n);
        {regWr, regRd, inValid} <= 3'b000;
        repeat (n) @(posedge sys_clk);
    endtask
    // one beat, held until inReady accepts it or the wait runs out
    task automatic send(logic [1:0] c, logic [31:0] d, logic l, logic u,
                        logic [3:0] pm, logic fw);
        int n = 0;
        {regWr, regRd, inValid} <= 3'b001;
        {inChannel, inData, inLast, inUnaligned} <= {c, d, l, u};
        pmQ.push_back(pm);
        if (fw)
            outQ.push_back({1'b0, d});
        do
            @(posedge sys_clk);
        while (inReady !== 1'b1 && ++n < 50);
        `CHK("accept", 1'b1, inReady)
    endtask
    task automatic finishTest();
        $display("checks %0d errors %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // scoreboard: every result takes the oldest note of its kind
    always @(posedge sys_clk)
    begin
        rdPend <= regRd;
        pmPend <= inValid && inReady;
        if (rdPend)
        begin
            eRd = rdQ.pop_front();
            `CHK("rdata", eRd, regRdata)
        end
        if (pmPend)
        begin
            ePm = pmQ.pop_front();
            `CHK("match", ePm, patternMatch)
        end
        if (outValid && outReady)
        begin
            eOut = outQ.pop_front();
            `CHK("out", eOut, {outCrcWrite, outData})
        end
        cycles++;
        if (cycles == 5000)
        begin
            badCount++;
            finishTest();
        end
    end
    // main sequence
    initial
    begin
        void'($urandom(89));
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        for (int c = 0; c < 4; c++)
            rd(PAT + 8'(4 * c), 32'h0);
        rd(8'h40, 32'h0);
        wr(CTL, 32'hffffffff);
        rd(CTL, 32'h67);
        wr(PAT, 32'hffffff5a);
        rd(PAT, 32'h5a);
        // every select code; only the attached channel moves the crc
        for (int s = 0; s < 8; s++)
        begin
            wr(CTL, 32'(s));
            wr(CRC, 32'hffffffff);
            acc = 32'hffffffff;
            for (int c = 0; c < 4; c++)
            begin
                w[c] = $urandom;
                send(2'(c), w[c], 1'b0, 1'b0, 4'h0, 1'b1);
                acc = c == s ? lfsr(acc, w[c]) : acc;
            end
            idle(3);
            rd(CRC, acc);
        end
        wr(CTL, 32'h20);
        wr(CRC, 32'h0);
        send(2'd0, w[1], 1'b0, 1'b0, 4'h0, 1'b1);
        idle(3);
        rd(CRC, {16'h0, ~ocs(w[1])});
        // swapped order: append refused, aligned reversed, unaligned dropped
        wr(CTL, 32'h40);
        wr(CFG, 32'h1);
        rd(CTL, 32'h0);
        wr(CTL, 32'h44);
        rd(CTL, 32'h4);
        outQ.push_back({1'b0, {<<8{w[2]}}});
        send(2'd1, w[2], 1'b0, 1'b0, 4'h0, 1'b0);
        send(2'd1, w[3], 1'b0, 1'b1, 4'h0, 1'b0);
        idle(3);
        rd(STS, 32'h2);
        wr(STS, 32'h2);
        rd(STS, 32'h0);
        // append on ch0 with a slow sink; ch1 still passes through
        wr(CFG, 32'h0);
        wr(CTL, 32'h40);
        wr(CRC, 32'hffffffff);
        sinkMode <= 2'd1;
        acc = 32'hffffffff;
        send(2'd1, w[0], 1'b0, 1'b0, 4'h0, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            acc = lfsr(acc, w[i]);
            send(2'd0, w[i], i == 2, 1'b0, 4'h0, 1'b0);
        end
        outQ.push_back({1'b1, acc});
        idle(30);
        // terminate on match for ch2 only; ch3 holds the same byte
        wr(CTL, 32'h0);
        wr(CFG, 32'h40);
        wr(PAT + 8'h08, 32'ha5);
        wr(PAT + 8'h0c, 32'ha5);
        sinkMode <= 2'd0;
        send(2'd2, 32'h123456a5, 1'b0, 1'b0, 4'h4, 1'b1);
        send(2'd3, 32'h123456a5, 1'b0, 1'b0, 4'h0, 1'b1);
        send(2'd2, 32'h123456a4, 1'b0, 1'b0, 4'h0, 1'b1);
        idle(4);
        // stalled sink: three words queue and ready holds input off, then the fifo drains
        sinkMode <= 2'd2;
        for (int i = 0; i < 3; i++)
            send(2'd3, w[i], 1'b0, 1'b0, 4'h0, 1'b1);
        idle(3);
        `CHK("full", 1'b0, inReady)
        sinkMode <= 2'd0;
        idle(10);
        `CHK("drain", 1'b0, outValid)
        `CHK("left", 0, outQ.size())
        finishTest();
    end
endmodule
bind dcp_crc_pattern dcp_crc_pattern_properties u_props
(
    .sys_clk, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .inValid, .inReady, .inChannel, .inLast, .outValid, .outReady,
    .outData, .outCrcWrite, .patternMatch
);
